// ---- bench/flash_array_model.sv ----
// Purpose: behavioural program flash array on the controller's far side
// Assumes: the read word is wanted at the first rising edge after the strobe
// Notes:   word derives from the address so high and low bytes differ
`default_nettype none
module flash_array_model (
   // clock
   input  wire logic        clk,
   // read port
   input  wire logic        flash_rd_en,
   input  wire logic [14:0] flash_rd_addr,
   output var  logic [15:0] flash_rd_word
);
   timeunit 1ns;
   timeprecision 1ns;
   initial flash_rd_word = 16'h0000;
   // word shown at the falling edge so it is settled at the capture edge;
   // toggling otherwise so stale data never matches
   always @(negedge clk)
      if (flash_rd_en)
         flash_rd_word <= {flash_rd_addr[7:0] ^ 8'h5a, flash_rd_addr[7:0]};
      else
         flash_rd_word <= ~flash_rd_word;
endmodule // flash_array_model
`default_nettype wire

// ---- bench/flash_sp_checker.sv ----
// Purpose: port assertions for the flash self-programming controller
// Assumes: fuse level only changes while reset is held
// Notes:   op kind zero means the sequencer is idle
`default_nettype none
module flash_sp_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // cpu side
   input wire logic        ctrl_wr,
   input wire logic [7:0]  ctrl_wdata,
   input wire logic [7:0]  selfprog_ctrl_status,
   input wire logic        store_exec,
   input wire logic        rd_valid,
   input wire logic        rd_blocked,
   input wire logic [7:0]  rd_data,
   // array and system side
   input wire logic        flash_op_start,
   input wire logic [1:0]  flash_op_kind,
   input wire logic        eeprom_write_busy,
   input wire logic        boot_reset_select_fuse,
   input wire logic [15:0] reset_vector,
   input wire logic        reset_vector_valid,
   input wire logic [5:0]  lock_bits,
   input wire logic        cpu_halt,
   input wire logic        spm_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   chk_vector_pick: assert property (
      reset_vector_valid |-> ((reset_vector == 16'h0000) == boot_reset_select_fuse))
      else $error("reset vector does not follow fuse");
   chk_lock_oneway: assert property (
      (lock_bits & ~$past(lock_bits)) == 6'h00)
      else $error("lock bit went back to one");
   chk_erase_start: assert property (
      ctrl_wr && ctrl_wdata[6:0] == 7'h03 && flash_op_kind == 2'h0 && !eeprom_write_busy
      ##[1:4] store_exec && !eeprom_write_busy |=> flash_op_start && flash_op_kind == 2'h1)
      else $error("erase did not start after store");
   chk_eeprom_reject: assert property (
      eeprom_write_busy && store_exec |=> !flash_op_start)
      else $error("operation started during eeprom write");
   chk_lock_nohalt: assert property (
      flash_op_kind == 2'h3 |-> !cpu_halt)
      else $error("cpu halted during lock programming");
   chk_blocked_ff: assert property (
      rd_blocked |-> rd_valid && rd_data == 8'hff)
      else $error("blocked read returned data");
   chk_store_timeout: assert property (
      ctrl_wr && ctrl_wdata[4:0] == 5'h03 && flash_op_kind == 2'h0 && !eeprom_write_busy
      ##1 !store_exec [*4] |-> ##2 selfprog_ctrl_status[4:0] == 5'h00)
      else $error("command not cleared after store window");
   chk_irq_level: assert property (
      spm_irq == (selfprog_ctrl_status[7] && !selfprog_ctrl_status[0]))
      else $error("interrupt level disagrees with enable bit");
endmodule // flash_sp_checker
bind flash_self_programming_ctrl flash_sp_checker flash_sp_checker_i (.*);
`default_nettype wire

// ---- bench/tb_flash_self_programming_ctrl.sv ----
// Purpose: directed bench for the flash self-programming controller
// Assumes: inputs change at falling edges; programming shortened to 20 cycles
// Notes:   read results pack valid, blocked and byte into one word
`default_nettype none
module tb_flash_self_programming_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, nrst = 1'b0, ctrl_wr = 1'b0, store_exec = 1'b0, rd_req = 1'b0;
   logic        eeprom_write_busy = 1'b0, boot_reset_select_fuse = 1'b1;
   logic [7:0]  ctrl_wdata = 8'h00, pointer_low_byte = 8'h00, pointer_high_byte = 8'h00;
   logic [15:0] data_register_pair = 16'h0000;
   logic [6:0]  buf_rd_idx = 7'h00;
   logic [7:0]  selfprog_ctrl_status, rd_data, flash_op_page;
   logic        rd_valid, rd_blocked, flash_rd_en, flash_op_start, reset_vector_valid;
   logic        cpu_halt, rww_read_block, spm_irq;
   logic [14:0] flash_rd_addr;
   logic [15:0] flash_rd_word, buf_rd_word, reset_vector;
   logic [1:0]  flash_op_kind;
   logic [5:0]  lock_bits;
   int          n_fail = 0, n_compared = 0;
   flash_self_programming_ctrl #(.PROG_CYCLES(17'd20)) flash_self_programming_ctrl_i (.*);
   flash_array_model flash_array_model_i (.*);
   // 50 ns period
   always #25 clk = ~clk;
   // ------------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------------
   task automatic tally_and_finish;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // command byte, then the store gap cycles later; gap 0 sends no store
   task automatic spm(input logic [7:0] cmd, input logic [15:0] ptr, input logic [15:0] d,
                      input int gap);
      {pointer_high_byte, pointer_low_byte} = ptr;
      data_register_pair = d;
      ctrl_wdata = cmd;
      ctrl_wr = 1'b1;
      tick(1);
      ctrl_wr = 1'b0;
      if (gap > 0)
      begin
         tick(gap - 1);
         store_exec = 1'b1;
         tick(1);
         store_exec = 1'b0;
      end
   endtask
   // bounded wait: a hung sequencer ends the run
   task automatic wait_idle;
      int i;
      for (i = 0; i < 80 && (selfprog_ctrl_status[0] !== 1'b0 || cpu_halt !== 1'b0); i++)
         tick(1);
      if (i == 80)
      begin
         n_fail++;
         $display("unexpected at %0t: sequencer stuck", $time);
         tally_and_finish;
      end
   endtask
   task automatic rd(input logic [15:0] ptr, input logic [15:0] exp);
      int i;
      {pointer_high_byte, pointer_low_byte} = ptr;
      rd_req = 1'b1;
      tick(1);
      rd_req = 1'b0;
      for (i = 0; i < 4 && rd_valid !== 1'b1; i++)
         tick(1);
      chk({6'h00, rd_valid, rd_blocked, rd_data}, exp);
   endtask
   task automatic bufchk(input logic [6:0] idx, input logic [15:0] exp);
      buf_rd_idx = idx;
      tick(2);
      chk(buf_rd_word, exp);
   endtask
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      tick(3);
      nrst = 1'b1;
      tick(4);
      chk(reset_vector, 16'h0000);
      chk({15'h0000, reset_vector_valid}, 16'h0001);
      bufchk(7'd3, 16'hffff);
      spm(8'h01, 16'h0006, 16'h1234, 4);
      wait_idle;
      spm(8'h01, 16'h0000, 16'habcd, 1);
      wait_idle;
      spm(8'h01, 16'h0006, 16'h5555, 2);
      wait_idle;
      bufchk(7'd3, 16'h1234);
      bufchk(7'd0, 16'habcd);
      spm(8'h83, 16'h1002, 16'h0000, 1);
      pointer_high_byte = 8'h00;
      tick(1);
      chk({6'h00, flash_op_kind, flash_op_page}, 16'h0110);
      chk({13'h0000, rww_read_block, selfprog_ctrl_status[6], cpu_halt}, 16'h0006);
      rd(16'h0100, 16'h03ff);
      rd(16'he003, 16'h025b);
      rd(16'he002, 16'h0201);
      chk({15'h0000, spm_irq}, 16'h0000);
      wait_idle;
      tick(1);
      chk({14'h0000, spm_irq, selfprog_ctrl_status[6]}, 16'h0003);
      spm(8'h11, 16'h0000, 16'h0000, 3);
      wait_idle;
      tick(1);
      chk({15'h0000, selfprog_ctrl_status[6]}, 16'h0000);
      bufchk(7'd3, 16'hffff);
      spm(8'h01, 16'he102, 16'h4321, 1);
      wait_idle;
      spm(8'h05, 16'he100, 16'h0000, 1);
      chk({12'h000, cpu_halt, flash_op_start, flash_op_kind}, 16'h000e);
      wait_idle;
      bufchk(7'd1, 16'hffff);
      spm(8'h11, 16'h0000, 16'h0000, 1);
      wait_idle;
      spm(8'h09, 16'h0001, 16'h00f2, 4);
      chk({15'h0000, cpu_halt}, 16'h0000);
      wait_idle;
      chk({10'h000, lock_bits}, 16'h0032);
      spm(8'h03, 16'h2000, 16'h0000, 0);
      tick(6);
      chk({13'h0000, flash_op_kind, selfprog_ctrl_status[0]}, 16'h0000);
      spm(8'h01, 16'h0004, 16'h7777, 1);
      wait_idle;
      eeprom_write_busy = 1'b1;
      tick(2);
      bufchk(7'd2, 16'hffff);
      spm(8'h03, 16'h2000, 16'h0000, 1);
      tick(2);
      chk({14'h0000, flash_op_kind}, 16'h0000);
      eeprom_write_busy = 1'b0;
      tick(6);
      nrst = 1'b0;
      boot_reset_select_fuse = 1'b0;
      tick(3);
      nrst = 1'b1;
      tick(4);
      chk(reset_vector, 16'h7e00);
      tally_and_finish;
   end
endmodule // tb_flash_self_programming_ctrl
`default_nettype wire

// ---- core/flash_self_programming_ctrl.v ----
// Purpose: self-programming sequencer for on-chip program flash
// Assumes: cpu strobes are on clk; fuse input is a static level from fuse cells
// Notes:   programming time is counted here; the array only follows the pulses
`include "selfprog_defs.vh"
`default_nettype none

module flash_self_programming_ctrl #(
   parameter        WORD_BITS       = 7,
   parameter [15:0] BOOT_RESET_WORD = 16'h7e00,
   parameter [7:0]  NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'he0,
   parameter [16:0] PROG_CYCLES     = `PROG_TIME_US * `CLK_MHZ
) (
   // clock and reset
   input  wire                      clk,
   input  wire                      nrst,
   // cpu control byte
   input  wire                      ctrl_wr,
   input  wire [7:0]                ctrl_wdata,
   output reg  [7:0]                selfprog_ctrl_status,
   // store instruction
   input  wire                      store_exec,
   input  wire [7:0]                pointer_low_byte,
   input  wire [7:0]                pointer_high_byte,
   input  wire [15:0]               data_register_pair,
   // program memory byte read
   input  wire                      rd_req,
   output reg  [7:0]                rd_data,
   output reg                       rd_valid,
   output reg                       rd_blocked,
   // flash array
   output reg                       flash_rd_en,
   output reg  [14:0]               flash_rd_addr,
   input  wire [15:0]               flash_rd_word,
   output reg                       flash_op_start,
   output reg  [1:0]                flash_op_kind,
   output reg  [14-WORD_BITS:0]     flash_op_page,
   input  wire [WORD_BITS-1:0]      buf_rd_idx,
   output wire [15:0]               buf_rd_word,
   // system status
   input  wire                      eeprom_write_busy,
   input  wire                      boot_reset_select_fuse,
   output reg  [15:0]               reset_vector,
   output reg                       reset_vector_valid,
   output reg  [5:0]                lock_bits,
   output reg                       cpu_halt,
   output reg                       rww_read_block,
   output reg                       spm_irq
);

   localparam PAGE_BITS = 15 - WORD_BITS;

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_ARMED = 2'h1;
   localparam [1:0] ST_BUSY  = 2'h2;

   // ----------------------------------------------------------------------
   // address helpers
   // ----------------------------------------------------------------------
   function [PAGE_BITS-1:0] page_of;
      input [15:0] ptr;
      begin
         page_of = ptr[15:WORD_BITS+1];
      end
   endfunction

   function in_rww;
      input [PAGE_BITS-1:0] page;
      begin
         in_rww = ({8'h00, page} < {{PAGE_BITS{1'b0}}, NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE});
      end
   endfunction

   wire [15:0]           pointer = {pointer_high_byte, pointer_low_byte};
   wire [WORD_BITS-1:0]  ptr_word = pointer[WORD_BITS:1];
   wire [PAGE_BITS-1:0]  ptr_page = page_of(pointer);

   // control state
   reg [1:0]            state_reg;
   reg [2:0]            win_reg;
   reg [16:0]           prog_cnt_reg;
   reg [3:0]            cmd_reg;
   reg                  store_op_enable_reg;
   reg                  irq_en_reg;
   reg                  busy_reg;
   reg                  ee_prev_reg;
   reg                  buf_clear_reg;
   reg                  buf_wr_reg;
   reg [WORD_BITS-1:0]  buf_idx_reg;
   reg [15:0]           buf_data_reg;

   // read pipeline state
   reg                  rd_pend_reg;
   reg                  rd_sel_reg;

   // fuse synchroniser and capture
   reg                  fuse_meta_reg;
   reg                  fuse_sync_reg;
   reg [1:0]            vec_wait_reg;

   wire any_loaded;
   wire ee_rise = eeprom_write_busy && !ee_prev_reg;

   // ----------------------------------------------------------------------
   // temporary page buffer
   // ----------------------------------------------------------------------
   page_buffer #(
      .WORD_BITS (WORD_BITS),
      .DATA_W    (16)
   ) u_buf (
      .clk        (clk),
      .nrst       (nrst),
      .clear      (buf_clear_reg),
      .wr_en      (buf_wr_reg),
      .wr_idx     (buf_idx_reg),
      .wr_data    (buf_data_reg),
      .rd_idx     (buf_rd_idx),
      .rd_word    (buf_rd_word),
      .any_loaded (any_loaded)
   );

   // ----------------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------------
   // one process owns all command state so that a control write and a store
   // in the same cycle resolve in a single, fixed order
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg      <= ST_IDLE;
         win_reg        <= 3'h0;
         prog_cnt_reg   <= 17'h0;
         cmd_reg        <= 4'h0;
         store_op_enable_reg      <= 1'b0;
         irq_en_reg     <= 1'b0;
         busy_reg       <= 1'b0;
         cpu_halt       <= 1'b0;
         ee_prev_reg    <= 1'b0;
         buf_clear_reg  <= 1'b0;
         buf_wr_reg     <= 1'b0;
         buf_idx_reg    <= {WORD_BITS{1'b0}};
         buf_data_reg   <= 16'h0;
         flash_op_start <= 1'b0;
         flash_op_kind  <= `OP_NONE;
         flash_op_page  <= {PAGE_BITS{1'b0}};
         lock_bits      <= `LOCK_RESET;
      end
      else
      begin
         ee_prev_reg    <= eeprom_write_busy;
         flash_op_start <= 1'b0;
         buf_wr_reg     <= 1'b0;
         // eeprom write mid-load loses every loaded word
         buf_clear_reg  <= ee_rise && any_loaded;
         case (state_reg)
            ST_IDLE, ST_ARMED:
            begin
               if (ctrl_wr && !eeprom_write_busy)
               begin
                  irq_en_reg <= ctrl_wdata[`SPC_IRQEN_BIT];
                  store_op_enable_reg  <= ctrl_wdata[`SPC_ENABLE_BIT];
                  cmd_reg    <= ctrl_wdata[`SPC_ENABLE_BIT] ?
                                ctrl_wdata[`SPC_CMD_MSB:`SPC_CMD_LSB] : 4'h0;
                  win_reg    <= `STORE_WINDOW;
                  state_reg  <= ctrl_wdata[`SPC_ENABLE_BIT] ? ST_ARMED : ST_IDLE;
               end
               else if ((state_reg == ST_ARMED) && store_exec)
               begin
                  store_op_enable_reg <= 1'b0;
                  cmd_reg   <= 4'h0;
                  state_reg <= ST_IDLE;
                  if (!eeprom_write_busy)
                  begin
                     case (cmd_reg)
                        `CMD_LOAD:
                        begin
                           buf_wr_reg   <= 1'b1;
                           buf_idx_reg  <= ptr_word;
                           buf_data_reg <= data_register_pair;
                        end
                        `CMD_ERASE, `CMD_WRITE:
                        begin
                           // page latched; data pair ignored
                           store_op_enable_reg      <= 1'b1;
                           cmd_reg        <= cmd_reg;
                           state_reg      <= ST_BUSY;
                           prog_cnt_reg   <= PROG_CYCLES - 17'h1;
                           flash_op_start <= 1'b1;
                           flash_op_page  <= ptr_page;
                           flash_op_kind  <= (cmd_reg == `CMD_ERASE) ?
                                             `OP_ERASE : `OP_WRITE;
                           busy_reg       <= 1'b1;
                           cpu_halt       <= !in_rww(ptr_page);
                        end
                        `CMD_LOCK:
                        begin
                           // zero bits program, pointer ignored, no blocking
                           lock_bits      <= lock_bits & data_register_pair[5:0];
                           store_op_enable_reg      <= 1'b1;
                           cmd_reg        <= cmd_reg;
                           state_reg      <= ST_BUSY;
                           prog_cnt_reg   <= PROG_CYCLES - 17'h1;
                           flash_op_start <= 1'b1;
                           flash_op_kind  <= `OP_LOCK;
                        end
                        `CMD_REENABLE:
                        begin
                           busy_reg      <= 1'b0;
                           buf_clear_reg <= 1'b1;
                        end
                        default:
                        begin
                           buf_wr_reg <= 1'b0;
                        end
                     endcase
                  end
               end
               else if (state_reg == ST_ARMED)
               begin
                  if (win_reg == 3'h1)
                  begin
                     // window over with no store: drop the command
                     store_op_enable_reg <= 1'b0;
                     cmd_reg   <= 4'h0;
                     state_reg <= ST_IDLE;
                  end
                  else
                  begin
                     win_reg <= win_reg - 3'h1;
                  end
               end
            end
            ST_BUSY:
            begin
               // only the interrupt enable is writable mid-operation
               if (ctrl_wr)
               begin
                  irq_en_reg <= ctrl_wdata[`SPC_IRQEN_BIT];
               end
               if (prog_cnt_reg == 17'h0)
               begin
                  store_op_enable_reg     <= 1'b0;
                  cmd_reg       <= 4'h0;
                  cpu_halt      <= 1'b0;
                  state_reg     <= ST_IDLE;
                  buf_clear_reg <= ee_rise && any_loaded || (flash_op_kind == `OP_WRITE);
                  flash_op_kind <= `OP_NONE;
               end
               else
               begin
                  prog_cnt_reg <= prog_cnt_reg - 17'h1;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // status byte, section block and interrupt
   // ----------------------------------------------------------------------
   // these trail the command state by one clock
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         selfprog_ctrl_status <= 8'h0;
         rww_read_block       <= 1'b0;
         spm_irq              <= 1'b0;
      end
      else
      begin
         selfprog_ctrl_status <= {irq_en_reg, busy_reg, 1'b0, cmd_reg, store_op_enable_reg};
         rww_read_block       <= busy_reg;
         spm_irq              <= irq_en_reg && !store_op_enable_reg; // level, not pulse
      end
   end

   // ----------------------------------------------------------------------
   // program memory byte reads
   // ----------------------------------------------------------------------
   // array returns the word one clock after the address; the byte is picked
   // here so the array stays word wide
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         flash_rd_en   <= 1'b0;
         flash_rd_addr <= 15'h0;
         rd_pend_reg   <= 1'b0;
         rd_sel_reg    <= 1'b0;
         rd_data       <= 8'h0;
         rd_valid      <= 1'b0;
         rd_blocked    <= 1'b0;
      end
      else
      begin
         flash_rd_en <= 1'b0;
         rd_valid    <= 1'b0;
         rd_blocked  <= 1'b0;
         if (rd_req && busy_reg && in_rww(ptr_page))
         begin
            // rww section busy: answer at once, never touch the array
            rd_valid   <= 1'b1;
            rd_blocked <= 1'b1;
            rd_data    <= `BLOCKED_BYTE;
         end
         else if (rd_req)
         begin
            flash_rd_en   <= 1'b1;
            flash_rd_addr <= pointer[15:1];
            rd_sel_reg    <= pointer[0];
         end
         rd_pend_reg <= rd_req && !(busy_reg && in_rww(ptr_page));
         if (rd_pend_reg)
         begin
            rd_valid <= 1'b1;
            rd_data  <= rd_sel_reg ? flash_rd_word[15:8] : flash_rd_word[7:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // reset vector from boot reset fuse
   // ----------------------------------------------------------------------
   // fuse is read only here; no path from the cpu reaches it
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fuse_meta_reg <= 1'b1;
         fuse_sync_reg <= 1'b1;
      end
      else
      begin
         fuse_meta_reg <= boot_reset_select_fuse;
         fuse_sync_reg <= fuse_meta_reg;
      end
   end

   // capture once the synchroniser has filled after release
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         vec_wait_reg       <= 2'h0;
         reset_vector       <= `APP_RESET_WORD;
         reset_vector_valid <= 1'b0;
      end
      else if (!reset_vector_valid)
      begin
         if (vec_wait_reg == 2'h2)
         begin
            reset_vector       <= fuse_sync_reg ? `APP_RESET_WORD : BOOT_RESET_WORD;
            reset_vector_valid <= 1'b1;
         end
         else
         begin
            vec_wait_reg <= vec_wait_reg + 2'h1;
         end
      end
   end

endmodule // flash_self_programming_ctrl

`default_nettype wire

// ---- core/page_buffer.v ----
// Purpose: temporary page buffer, one word per slot, held in flip-flops
// Assumes: one clock, clear and write are single-cycle pulses
// Notes:   an empty slot reads as erased; a loaded slot cannot be reloaded
`include "selfprog_defs.vh"
`default_nettype none

module page_buffer #(
   parameter WORD_BITS = 7,
   parameter DATA_W    = 16
) (
   // clock and reset
   input  wire                 clk,
   input  wire                 nrst,
   // write side
   input  wire                 clear,
   input  wire                 wr_en,
   input  wire [WORD_BITS-1:0] wr_idx,
   input  wire [DATA_W-1:0]    wr_data,
   // read side
   input  wire [WORD_BITS-1:0] rd_idx,
   output reg  [DATA_W-1:0]    rd_word,
   output wire                 any_loaded
);

   localparam DEPTH = 1 << WORD_BITS;

   reg [DATA_W-1:0] mem_reg [0:DEPTH-1];
   reg [DEPTH-1:0]  loaded_reg;
   integer          i;

   assign any_loaded = |loaded_reg;

   // ----------------------------------------------------------------------
   // slot flags: reset and clear empty the whole buffer
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         loaded_reg <= {DEPTH{1'b0}};
      end
      else if (clear)
      begin
         loaded_reg <= {DEPTH{1'b0}};
      end
      else if (wr_en)
      begin
         loaded_reg[wr_idx] <= 1'b1;    // any slot order accepted
      end
   end

   // data store: a second load of a filled slot has no effect
   always @(posedge clk)
   begin
      for (i = 0; i < DEPTH; i = i + 1)
      begin
         if (wr_en && !clear && !loaded_reg[wr_idx] && (wr_idx == i))
         begin
            mem_reg[i] <= wr_data;
         end
      end
   end

   // registered read port for the array during page write
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_word <= `ERASED_WORD;
      end
      else
      begin
         rd_word <= loaded_reg[rd_idx] ? mem_reg[rd_idx] : `ERASED_WORD;
      end
   end

endmodule // page_buffer

`default_nettype wire

// ---- core/selfprog_defs.vh ----
// Purpose: shared constants of the flash self-programming controller
// Assumes: included by bare name from every design file under core/
// Notes:   definitions only, no logic
`ifndef SELFPROG_DEFS_VH
`define SELFPROG_DEFS_VH

// ----------------------------------------------------------------------
// control/status byte field positions
// ----------------------------------------------------------------------
`define SPC_ENABLE_BIT    0
`define SPC_CMD_LSB       1
`define SPC_CMD_MSB       4
`define SPC_BUSY_BIT      6
`define SPC_IRQEN_BIT     7

// ----------------------------------------------------------------------
// command codes held in the four command bits above the enable bit
// ----------------------------------------------------------------------
`define CMD_LOAD          4'h0
`define CMD_ERASE         4'h1
`define CMD_WRITE         4'h2
`define CMD_LOCK          4'h4
`define CMD_REENABLE      4'h8

// ----------------------------------------------------------------------
// operation kinds shown to the flash array
// ----------------------------------------------------------------------
`define OP_NONE           2'h0
`define OP_ERASE          2'h1
`define OP_WRITE          2'h2
`define OP_LOCK           2'h3

// ----------------------------------------------------------------------
// reset values and fixed patterns
// ----------------------------------------------------------------------
`define APP_RESET_WORD    16'h0000
`define LOCK_RESET        6'h3f
`define ERASED_WORD       16'hffff
`define BLOCKED_BYTE      8'hff

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define STORE_WINDOW      3'h4
`define CLK_MHZ           17'd20
`define PROG_TIME_US      17'd3700

`endif
